// ==== design/cim_defines.vh ====
// register offsets, field positions, reset values and command codes of the translation control block
`ifndef CIM_DEFINES_VH
`define CIM_DEFINES_VH

// register byte offsets
`define CIM_OFS_TABLE_BASE 8'h00
`define CIM_OFS_STATUS 8'h04
`define CIM_OFS_COMMAND 8'h08
`define CIM_OFS_FAULT_ADDR 8'h0c
`define CIM_OFS_INVALIDATE 8'h10
`define CIM_OFS_RAW_INT 8'h14
`define CIM_OFS_INT_CLEAR 8'h18
`define CIM_OFS_INT_ENABLE 8'h1c
`define CIM_OFS_MASKED_INT 8'h20
`define CIM_OFS_AUTO_GATE 8'h24

// status field positions
`define CIM_ST_PAGING 0
`define CIM_ST_FAULT_MODE 1
`define CIM_ST_HOLD 2
`define CIM_ST_IDLE 3
`define CIM_ST_REPLAY_EMPTY 4
`define CIM_ST_DIRECTION 5
`define CIM_ST_MASTER_LO 6
`define CIM_ST_MASTER_HI 10

// interrupt bit positions
`define CIM_INT_FAULT 0
`define CIM_INT_BUS_ERR 1

// command field and its codes
`define CIM_CMD_HI 2
`define CIM_CMD_PAGING_ON 3'h0
`define CIM_CMD_PAGING_OFF 3'h1
`define CIM_CMD_HOLD_ON 3'h2
`define CIM_CMD_HOLD_OFF 3'h3
`define CIM_CMD_FLUSH 3'h4
`define CIM_CMD_FAULT_DONE 3'h5
`define CIM_CMD_FORCE_RESET 3'h6

// reset values
`define CIM_RST_WORD 32'h0000_0000
`define CIM_RST_AUTO_GATE 1'h1

`endif

// ==== design/cim_flag.v ====
// sticky event flag with set-over-clear priority
`timescale 1ns/1ns
module cim_flag
(
  // clock, reset and freeze
  input wire sys_clk,
  input wire srst,
  input wire ce,
  // hardware event
  input wire set_evt,
  // software write-one-to-clear
  input wire clr_evt,
  // software direct write of the flag
  input wire wr_evt,
  input wire wr_val,
  // flag state
  output reg flag_r
);

  // next value of the flag
  reg flag_nxt;

  // a hardware event always wins so an event landing on a clear is not lost
  always @*
  begin
    flag_nxt = flag_r;
    if (wr_evt)
    begin
      flag_nxt = wr_val;
    end
    if (clr_evt)
    begin
      flag_nxt = 1'h0;
    end
    if (set_evt)
    begin
      flag_nxt = 1'h1;
    end
  end

  // flag register, frozen while ce is low
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      flag_r <= 1'h0;
    end
    else if (ce)
    begin
      flag_r <= flag_nxt;
    end
  end

endmodule

// ==== design/cim_ctrl.v ====
// control, status, fault capture and interrupt logic of the codec address-translation unit
`timescale 1ns/1ns
`include "cim_defines.vh"
// Overview of operation
// - command codes 0..6 select paging, hold, flush, fault done, reset
// - status bit 2 shows hold mode active
// - status bit 1 shows fault mode active
// - status bit 3 idle: translating, nothing outstanding
// - status bit 4 shows replay buffer empty
// - fault direction kept in status bit 5
// - faulting master index kept in bits 10:6
// - full logical address of last fault kept
// - invalidate write removes one table-cache entry
// - raw flags: bit1 bus error, bit0 fault
// - write one clears raw flag, zero ignored
// - enable bit admits source into interrupt signalling
// - auto gating bit lets block gate own clock
// - table base held in 32-bit read/write register
module cim_ctrl #
(
  parameter MASTER_W = 5,
  parameter ADDR_W = 8
)
(
  // clock, reset and freeze
  input wire sys_clk,
  input wire srst,
  input wire ce,
  // register port
  input wire reg_sel,
  input wire reg_wr,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_rvalid,
  // translation engine events and state
  input wire fault_evt,
  input wire [31:0] fault_addr,
  input wire fault_is_write,
  input wire [MASTER_W-1:0] fault_master,
  input wire bus_err_evt,
  input wire xlat_active,
  input wire xlat_pending,
  input wire replay_empty,
  // controls toward the translation engine
  output reg [31:0] table_base_field,
  output reg paging_on_r,
  output reg hold_mode_on,
  output reg flush_all_r,
  output reg inval_req_r,
  output reg [31:0] inval_addr_r,
  output reg force_reset_r,
  output reg clk_gate_r,
  output wire irq
);

  // decoded write strobes
  wire wr_go;
  wire [2:0] cmd_code;
  wire cmd_wr;
  // fault mode, fault record
  reg fault_mode_r;
  reg fault_mode_nxt;
  reg fault_direction;
  reg [MASTER_W-1:0] faulting_master_index;
  reg [31:0] fault_addr_r;
  // interrupt enables and gating control
  reg [1:0] int_en_r;
  reg auto_gate_r;
  // raw and masked interrupt views
  wire [1:0] raw_int;
  wire [1:0] masked_int;
  // status word and read mux result
  wire [31:0] status_word;
  reg [31:0] rd_mux;
  // idle for gating purposes
  wire quiet;

  // true when the register address matches the given offset; callers gate it with wr_go
  function hit;
    input [ADDR_W-1:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs[ADDR_W-1:0]);
    end
  endfunction

  assign wr_go = reg_sel & reg_wr & ce;
  assign cmd_code = reg_wdata[`CIM_CMD_HI:0];
  assign cmd_wr = wr_go & hit(reg_addr, `CIM_OFS_COMMAND);

  // page-table base register; software must load it before paging is enabled
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      table_base_field <= `CIM_RST_WORD;
    end
    else if (wr_go & hit(reg_addr, `CIM_OFS_TABLE_BASE))
    begin
      table_base_field <= reg_wdata;
    end
  end

  // paging and hold mode follow the command register only
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      paging_on_r <= 1'h0;
      hold_mode_on <= 1'h0;
    end
    else if (ce & cmd_wr)
    begin
      case (cmd_code)
        `CIM_CMD_PAGING_ON:
        begin
          paging_on_r <= 1'h1;
        end
        `CIM_CMD_PAGING_OFF:
        begin
          paging_on_r <= 1'h0;
        end
        `CIM_CMD_HOLD_ON:
        begin
          hold_mode_on <= 1'h1;
        end
        `CIM_CMD_HOLD_OFF:
        begin
          hold_mode_on <= 1'h0;
        end
        `CIM_CMD_FORCE_RESET:
        begin
          // force reset drops every mode the engine was in
          paging_on_r <= 1'h0;
          hold_mode_on <= 1'h0;
        end
        default:
        begin
          // flush, fault done and code 7 leave paging and hold alone
          paging_on_r <= paging_on_r;
        end
      endcase
    end
  end

  // one-cycle command pulses toward the engine
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      flush_all_r <= 1'h0;
      force_reset_r <= 1'h0;
    end
    else if (ce)
    begin
      flush_all_r <= cmd_wr & (cmd_code == `CIM_CMD_FLUSH);
      force_reset_r <= cmd_wr & (cmd_code == `CIM_CMD_FORCE_RESET);
    end
  end

  // single-entry invalidate: the written address goes out with a one-cycle request
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      inval_req_r <= 1'h0;
      inval_addr_r <= `CIM_RST_WORD;
    end
    else if (ce)
    begin
      inval_req_r <= wr_go & hit(reg_addr, `CIM_OFS_INVALIDATE);
      if (wr_go & hit(reg_addr, `CIM_OFS_INVALIDATE))
      begin
        inval_addr_r <= reg_wdata;
      end
    end
  end

  // fault mode: a fault enters it, the fault-done command or force reset leaves it
  always @*
  begin
    fault_mode_nxt = fault_mode_r;
    if (cmd_wr & ((cmd_code == `CIM_CMD_FAULT_DONE) | (cmd_code == `CIM_CMD_FORCE_RESET)))
    begin
      fault_mode_nxt = 1'h0;
    end
    // a new fault in the acknowledge cycle keeps the mode on
    if (fault_evt)
    begin
      fault_mode_nxt = 1'h1;
    end
  end

  // fault mode register and fault record; every fault overwrites the record
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      fault_mode_r <= 1'h0;
      fault_direction <= 1'h0;
      faulting_master_index <= {MASTER_W{1'b0}};
      fault_addr_r <= `CIM_RST_WORD;
    end
    else if (ce)
    begin
      fault_mode_r <= fault_mode_nxt;
      if (fault_evt)
      begin
        fault_direction <= fault_is_write;
        faulting_master_index <= fault_master;
        fault_addr_r <= fault_addr;
      end
    end
  end

  // raw fault flag: the fault event wins over a clear in the same cycle
  cim_flag u_fault_flag
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .set_evt(fault_evt),
    .clr_evt(wr_go & hit(reg_addr, `CIM_OFS_INT_CLEAR) & reg_wdata[`CIM_INT_FAULT]),
    .wr_evt(wr_go & hit(reg_addr, `CIM_OFS_RAW_INT)),
    .wr_val(reg_wdata[`CIM_INT_FAULT]),
    .flag_r(raw_int[`CIM_INT_FAULT])
  );

  // raw read-bus-error flag
  cim_flag u_bus_err_flag
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .set_evt(bus_err_evt),
    .clr_evt(wr_go & hit(reg_addr, `CIM_OFS_INT_CLEAR) & reg_wdata[`CIM_INT_BUS_ERR]),
    .wr_evt(wr_go & hit(reg_addr, `CIM_OFS_RAW_INT)),
    .wr_val(reg_wdata[`CIM_INT_BUS_ERR]),
    .flag_r(raw_int[`CIM_INT_BUS_ERR])
  );

  // enable and auto gating registers
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      int_en_r <= 2'h0;
      auto_gate_r <= `CIM_RST_AUTO_GATE;
    end
    else if (wr_go)
    begin
      if (hit(reg_addr, `CIM_OFS_INT_ENABLE))
      begin
        int_en_r <= reg_wdata[1:0];
      end
      if (hit(reg_addr, `CIM_OFS_AUTO_GATE))
      begin
        auto_gate_r <= reg_wdata[0];
      end
    end
  end

  // masked view and the single interrupt line
  assign masked_int = raw_int & int_en_r;
  assign irq = |masked_int;

  // gating is only safe with no translation running, pending or waiting to replay
  assign quiet = ~xlat_active & ~xlat_pending & replay_empty;

  // clock gate request, registered so the gate cell sees a glitch-free level
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      clk_gate_r <= 1'h0;
    end
    else if (ce)
    begin
      clk_gate_r <= auto_gate_r & quiet;
    end
  end

  // status word; live engine state is read as it stands
  assign status_word = {
    {(31 - `CIM_ST_MASTER_HI){1'b0}},
    faulting_master_index,
    fault_direction,
    replay_empty,
    xlat_active & ~xlat_pending,
    hold_mode_on,
    fault_mode_r,
    paging_on_r
  };

  // read mux; write-only and unmapped offsets read as zero
  always @*
  begin
    rd_mux = `CIM_RST_WORD;
    case (reg_addr)
      `CIM_OFS_TABLE_BASE: rd_mux = table_base_field;
      `CIM_OFS_STATUS: rd_mux = status_word;
      `CIM_OFS_FAULT_ADDR: rd_mux = fault_addr_r;
      `CIM_OFS_RAW_INT: rd_mux = {30'h0, raw_int};
      `CIM_OFS_INT_ENABLE: rd_mux = {30'h0, int_en_r};
      `CIM_OFS_MASKED_INT: rd_mux = {30'h0, masked_int};
      `CIM_OFS_AUTO_GATE: rd_mux = {31'h0, auto_gate_r};
      default: rd_mux = `CIM_RST_WORD;
    endcase
  end

  // read data is registered, answering one cycle after the read is taken
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      reg_rdata <= `CIM_RST_WORD;
      reg_rvalid <= 1'h0;
    end
    else if (ce)
    begin
      reg_rvalid <= reg_sel & ~reg_wr;
      if (reg_sel & ~reg_wr)
      begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule

// ==== tb/cim_engine_model.sv ====
// translation engine stand-in: event pulses and busy levels
`timescale 1ns/1ns
module cim_engine_model
(
  // clock
  input wire sys_clk,
  // bench controls
  input wire [1:0] trig,
  input wire [1:0] busy,
  input wire [37:0] info,
  // engine side
  output reg fault_evt = 1'b0,
  output reg bus_err_evt = 1'b0,
  output wire fault_is_write,
  output wire [4:0] fault_master,
  output wire [31:0] fault_addr,
  output wire xlat_active,
  output wire xlat_pending,
  output wire replay_empty
);
  // record launched with the pulse
  reg [37:0] held_r = 38'h0;
  // one-cycle pulses on the edge after the bench asks
  always @(posedge sys_clk)
  begin
    fault_evt <= trig[0];
    bus_err_evt <= trig[1];
    held_r <= info;
  end
  // outside the pulse the record is scrambled, so a late sample is caught
  assign {fault_is_write, fault_master, fault_addr} = fault_evt ? held_r : ~held_r;
  assign xlat_active = busy[0];
  assign xlat_pending = busy[1];
  assign replay_empty = ~busy[1];
endmodule

// ==== tb/cim_ctrl_asserts.sv ====
// port checker for the translation control block
`timescale 1ns/1ns
module cim_ctrl_asserts #(parameter MASTER_W = 5, parameter ADDR_W = 8)
(
  // clock, reset, freeze
  input wire sys_clk,
  input wire srst,
  input wire ce,
  // register port
  input wire reg_sel,
  input wire reg_wr,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  // events
  input wire fault_evt,
  input wire bus_err_evt,
  // controls
  input wire [31:0] table_base_field,
  input wire paging_on_r,
  input wire hold_mode_on,
  input wire flush_all_r,
  input wire inval_req_r,
  input wire [31:0] inval_addr_r,
  input wire force_reset_r,
  input wire irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // accepted write, and accepted command write
  wire wt = ce && reg_sel && reg_wr;
  wire ct = wt && reg_addr == 8'h08;
  wire [2:0] cd = reg_wdata[2:0];
  // anything that may legally raise the interrupt line
  wire cause = fault_evt || bus_err_evt || wt;
  paging_set_a: assert property (ct && cd == 3'h0 |=> paging_on_r)
    else $error("paging not set");
  paging_clear_a: assert property (ct && cd == 3'h1 |=> !paging_on_r)
    else $error("paging not cleared");
  hold_set_a: assert property (ct && cd == 3'h2 |=> hold_mode_on)
    else $error("hold not set");
  hold_clear_a: assert property (ct && cd == 3'h3 |=> !hold_mode_on)
    else $error("hold not cleared");
  flush_pulse_a: assert property (ct && cd == 3'h4 |=> flush_all_r)
    else $error("flush missing");
  force_clear_a: assert property (ct && cd == 3'h6 |=> force_reset_r && !paging_on_r && !hold_mode_on)
    else $error("force reset wrong");
  inval_take_a: assert property (wt && reg_addr == 8'h10 |=> inval_req_r && inval_addr_r == $past(reg_wdata))
    else $error("invalidate wrong");
  base_write_a: assert property (wt && reg_addr == 8'h00 |=> table_base_field == $past(reg_wdata))
    else $error("base not written");
  irq_cause_a: assert property ($rose(irq) |-> $past(cause))
    else $error("irq without cause");
endmodule
bind cim_ctrl cim_ctrl_asserts #(.MASTER_W(MASTER_W), .ADDR_W(ADDR_W)) chk_i (.sys_clk, .srst, .ce, .reg_sel,
  .reg_wr, .reg_addr, .reg_wdata, .fault_evt, .bus_err_evt, .table_base_field, .paging_on_r, .hold_mode_on,
  .flush_all_r, .inval_req_r, .inval_addr_r, .force_reset_r, .irq);

// ==== tb/test_codec_iommu_control.sv ====
// self-checking bench for the translation control block
`timescale 1ns/1ns
module test_codec_iommu_control;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg ce = 1'b1;
  reg reg_sel = 1'b0;
  reg reg_wr = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg [1:0] trig = 2'h0;
  reg [1:0] busy = 2'h0;
  reg [37:0] info = 38'h0;
  reg [7:0] a;
  wire [31:0] reg_rdata, table_base_field, inval_addr_r, fault_addr;
  wire reg_rvalid, paging_on_r, hold_mode_on, flush_all_r, inval_req_r, force_reset_r, clk_gate_r, irq;
  wire fault_evt, fault_is_write, bus_err_evt, xlat_active, xlat_pending, replay_empty;
  wire [4:0] fault_master;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  cim_engine_model eng (.sys_clk, .trig, .busy, .info, .fault_evt, .bus_err_evt, .fault_is_write,
    .fault_master, .fault_addr, .xlat_active, .xlat_pending, .replay_empty);
  cim_ctrl uut (.sys_clk, .srst, .ce, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .fault_evt, .fault_addr, .fault_is_write, .fault_master, .bus_err_evt, .xlat_active, .xlat_pending,
    .replay_empty, .table_base_field, .paging_on_r, .hold_mode_on, .flush_all_r, .inval_req_r,
    .inval_addr_r, .force_reset_r, .clk_gate_r, .irq);
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one access, held across exactly one rising edge
  task acc(input w, input [7:0] ad, input [31:0] d);
    begin
      @(negedge sys_clk);
      reg_sel = 1'b1;
      reg_wr = w;
      reg_addr = ad;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_sel = 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [31:0] e);
    begin
      acc(1'b0, ad, 32'h0);
      chk(reg_rvalid, 32'h1);
      chk(reg_rdata, e);
    end
  endtask
  // engine pulse, taken by the block two edges later
  task fire(input [1:0] t);
    begin
      @(negedge sys_clk);
      trig = t;
      @(negedge sys_clk);
      trig = 2'h0;
      @(negedge sys_clk);
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // hang guard
  initial
  begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
  initial
  begin
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    // reset values; status shows only the empty replay buffer
    for (a = 8'h00; a < 8'h28; a = a + 8'h04)
      rd(a, a == 8'h04 ? 32'h10 : {31'h0, a == 8'h24});
    chk(clk_gate_r, 32'h1);
    acc(1'b1, 8'h00, 32'hdead_beef);
    rd(8'h00, 32'hdead_beef);
    ce = 1'b0;
    acc(1'b1, 8'h00, 32'h0);
    ce = 1'b1;
    rd(8'h00, 32'hdead_beef);
    acc(1'b1, 8'h08, 32'h0);
    acc(1'b1, 8'h08, 32'h2);
    rd(8'h04, 32'h15);
    acc(1'b1, 8'h08, 32'h6);
    chk({force_reset_r, paging_on_r, hold_mode_on}, 32'h4);
    acc(1'b1, 8'h08, 32'h4);
    chk(flush_all_r, 32'h1);
    acc(1'b1, 8'h1c, 32'h1);
    info = {1'b1, 5'h1b, 32'h1234_5678};
    fire(2'h1);
    chk(irq, 32'h1);
    rd(8'h04, 32'h6f2);
    rd(8'h0c, 32'h1234_5678);
    rd(8'h20, 32'h1);
    // a zero in the fault bit must leave it set
    acc(1'b1, 8'h18, 32'h2);
    rd(8'h14, 32'h1);
    acc(1'b1, 8'h18, 32'h1);
    chk(irq, 32'h0);
    acc(1'b1, 8'h08, 32'h5);
    rd(8'h04, 32'h6f0);
    fire(2'h2);
    rd(8'h14, 32'h2);
    chk(irq, 32'h0);
    acc(1'b1, 8'h1c, 32'h2);
    rd(8'h20, 32'h2);
    chk(irq, 32'h1);
    acc(1'b1, 8'h14, 32'h0);
    rd(8'h14, 32'h0);
    // a fault event and its clear land on one edge: the event must win
    fork
      acc(1'b1, 8'h18, 32'h1);
      begin
        trig = 2'h1;
        @(negedge sys_clk);
        trig = 2'h0;
      end
    join
    rd(8'h14, 32'h1);
    acc(1'b1, 8'h18, 32'h1);
    acc(1'b1, 8'h08, 32'h5);
    acc(1'b1, 8'h10, 32'hcafe_0040);
    chk(inval_addr_r, 32'hcafe_0040);
    chk(inval_req_r, 32'h1);
    rd(8'h10, 32'h0);
    rd(8'h28, 32'h0);
    acc(1'b1, 8'h04, 32'hffff_ffff);
    busy = 2'h1;
    rd(8'h04, 32'h6f8);
    chk(clk_gate_r, 32'h0);
    busy = 2'h3;
    rd(8'h04, 32'h6e0);
    busy = 2'h0;
    // paging and hold each go on and off; code 7 leaves both alone
    acc(1'b1, 8'h08, 32'h0);
    acc(1'b1, 8'h08, 32'h2);
    acc(1'b1, 8'h08, 32'h7);
    chk({paging_on_r, hold_mode_on}, 32'h3);
    acc(1'b1, 8'h08, 32'h1);
    rd(8'h04, 32'h6f4);
    acc(1'b1, 8'h08, 32'h3);
    chk(hold_mode_on, 32'h0);
    chk(clk_gate_r, 32'h1);
    acc(1'b1, 8'h24, 32'h0);
    repeat (2) @(negedge sys_clk);
    chk(clk_gate_r, 32'h0);
    end_sim;
  end
endmodule
